// File: rtl/wsm_timer.sv
// Purpose: windowed signal measure timer, 24-bit with byte access
// Assumes: software bus gives one byte strobe per cycle on clk_sys
// Notes: events are one-cycle pulses; no interrupt logic lives here
//        capture B keeps the capture before the newest one
`timescale 1ns/1ps
module wsm_timer
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control
    input wire logic enable,
    input wire logic narrowMode,
    // window pin
    input wire logic window_gate_input,
    // software byte access
    input wire logic swWrite,
    input wire logic swRead,
    input wire logic [1:0] swTarget,
    input wire logic [1:0] swByte,
    input wire logic [wsm_pkg::WSM_BYTE_W-1:0] swWdata,
    output logic [wsm_pkg::WSM_BYTE_W-1:0] swRdata,
    output logic swRvalid,
    // events and observed state
    output logic periodMatchIrq,
    output logic acqDoneIrq,
    output logic windowLevel,
    output logic running
);
    import wsm_pkg::*;

    // registers and internal nets
    wsm_state_t state_q, state_d;                 // measurement state
    logic [WSM_CNT_W-1:0] count_value_bytes_q;   // running counter
    logic [WSM_CNT_W-1:0] count_value_bytes_d;
    logic [WSM_CNT_W-1:0] captured_period_reg_q; // first capture register
    logic [WSM_CNT_W-1:0] capB_q;                // second capture register
    logic [WSM_CNT_W-1:0] match_q;               // period match value
    logic [WSM_BYTE_W-1:0] rdata_q;
    logic rvalid_q;
    logic matchIrq_q;
    logic doneIrq_q;
    logic winLevel;
    logic winRise;

    // pin crossing and edge detection
    wsm_edge_sync u_sync
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pinIn(window_gate_input),
        .levelOut(winLevel),
        .risePulse(winRise)
    );

    // decode of software access
    // byte code 3 selects nothing: writes dropped, reads zero
    wire wrCount = swWrite && (swTarget == WSM_TGT_COUNT);
    wire wrCapB = swWrite && (swTarget == WSM_TGT_CAPB);
    wire wrCapA = swWrite && (swTarget == WSM_TGT_CAPA);
    wire wrMatch = swWrite && (swTarget == WSM_TGT_MATCH);
    // narrow mode keeps bits 23:16 at zero when counting
    wire [WSM_CNT_W-1:0] cntMask = narrowMode ? WSM_NARROW_MASK : 24'hFFFFFF;
    wire [WSM_CNT_W-1:0] cntInc = (count_value_bytes_q + 24'h000001) & cntMask;
    wire [WSM_CNT_W-1:0] matchEff = match_q & cntMask;
    wire isRun = (state_q == WSM_RUN);
    // a window edge in run closes one measurement
    wire captureNow = enable && isRun && winRise;
    wire startNow = enable && !isRun && winRise;
    // no match flag in the cycle that closes a window
    wire hitMatch = enable && isRun && !winRise
        && ((count_value_bytes_q & cntMask) == matchEff);

    // byte write merge helper
    function automatic logic [23:0] putByte(input logic [23:0] v, input logic [1:0] b,
        input logic [7:0] d);
        logic [23:0] r;
        r = v;
        if (b == WSM_SEL_LOW)
            r[7:0] = d;
        else if (b == WSM_SEL_HIGH)
            r[15:8] = d;
        else if (b == WSM_SEL_UPPER)
            r[23:16] = d;
        return r;
    endfunction : putByte

    // byte read helper
    function automatic logic [7:0] getByte(input logic [23:0] v, input logic [1:0] b);
        logic [7:0] r;
        r = 8'h00;
        if (b == WSM_SEL_LOW)
            r = v[7:0];
        else if (b == WSM_SEL_HIGH)
            r = v[15:8];
        else if (b == WSM_SEL_UPPER)
            r = v[23:16];
        return r;
    endfunction : getByte

    // read mux for the selected register
    wire [WSM_CNT_W-1:0] rdSel = (swTarget == WSM_TGT_COUNT) ? count_value_bytes_q :
        (swTarget == WSM_TGT_CAPA) ? captured_period_reg_q :
        (swTarget == WSM_TGT_CAPB) ? capB_q : match_q;

    // next state and counter
    always_comb
    begin
        state_d = state_q;
        count_value_bytes_d = count_value_bytes_q;
        unique case (state_q)
            WSM_ARMED:
            begin
                // wait for first window edge
                if (startNow)
                begin
                    state_d = WSM_RUN;
                    count_value_bytes_d = WSM_CNT_RST;
                end
            end
            WSM_RUN:
            begin
                // dropping enable parks the timer, counter holds
                if (!enable)
                    state_d = WSM_ARMED;
                else if (captureNow)
                    count_value_bytes_d = WSM_CNT_RST;
                else
                    count_value_bytes_d = cntInc;
            end
        endcase
        // software write wins over counting
        if (wrCount)
            count_value_bytes_d = putByte(count_value_bytes_q, swByte, swWdata);
    end

    // state and counter registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= WSM_ARMED;
            count_value_bytes_q <= WSM_CNT_RST;
        end
        else
        begin
            state_q <= state_d;
            count_value_bytes_q <= count_value_bytes_d;
        end
    end

    // capture registers: hardware capture wins over software write
    // capture B keeps the previous measurement
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            captured_period_reg_q <= WSM_CNT_RST;
            capB_q <= WSM_CNT_RST;
        end
        else
        begin
            if (captureNow)
                captured_period_reg_q <= count_value_bytes_q & cntMask;
            else if (wrCapA)
                captured_period_reg_q <= putByte(captured_period_reg_q, swByte, swWdata);
            if (captureNow)
                capB_q <= captured_period_reg_q;
            else if (wrCapB)
                capB_q <= putByte(capB_q, swByte, swWdata);
        end
    end

    // period match register
    // a match only flags; the counter keeps running
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            match_q <= WSM_MATCH_RST;
        else if (wrMatch)
            match_q <= putByte(match_q, swByte, swWdata);
    end

    // event pulses and read port
    // read data hold until the next read request
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            matchIrq_q <= 1'b0;
            doneIrq_q <= 1'b0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            matchIrq_q <= hitMatch;
            doneIrq_q <= captureNow;
            rvalid_q <= swRead;
            if (swRead)
                rdata_q <= getByte(rdSel, swByte);
        end
    end

    // outputs straight from flops
    // running is the run bit of the one-hot state
    assign swRdata = rdata_q;
    assign swRvalid = rvalid_q;
    assign periodMatchIrq = matchIrq_q;
    assign acqDoneIrq = doneIrq_q;
    assign windowLevel = winLevel;
    assign running = state_q[1];
endmodule : wsm_timer

// File: rtl/wsm_pkg.sv
// Purpose: shared constants for the windowed signal measure timer
// Assumes: single clock domain, byte-wide software access
// Notes: byte select codes address the three bytes of each 24-bit value
package wsm_pkg;
    localparam int WSM_CNT_W = 24;          // full counter width
    localparam int WSM_BYTE_W = 8;          // width of one byte lane
    localparam int WSM_NARROW_W = 16;       // width in narrow mode
    localparam logic [23:0] WSM_CNT_RST = 24'h000000;   // counter reset value
    localparam logic [23:0] WSM_MATCH_RST = 24'hFFFFFF; // match reset value
    localparam logic [23:0] WSM_NARROW_MASK = 24'h00FFFF; // narrow mode mask
    // byte select codes
    localparam logic [1:0] WSM_SEL_LOW = 2'h0;
    localparam logic [1:0] WSM_SEL_HIGH = 2'h1;
    localparam logic [1:0] WSM_SEL_UPPER = 2'h2;
    // target select codes
    localparam logic [1:0] WSM_TGT_COUNT = 2'h0;
    localparam logic [1:0] WSM_TGT_CAPA = 2'h1;
    localparam logic [1:0] WSM_TGT_CAPB = 2'h2;
    localparam logic [1:0] WSM_TGT_MATCH = 2'h3;
    // measurement states, one-hot
    typedef enum logic [1:0] {
        WSM_ARMED = 2'b01,
        WSM_RUN = 2'b10
    } wsm_state_t;
endpackage : wsm_pkg

// File: rtl/wsm_edge_sync.sv
// Purpose: two-flop synchroniser and rising edge detector for the window pin
// Assumes: window input is asynchronous to clk_sys
// Notes: rise pulse lags the pin by three clock edges
`timescale 1ns/1ps
module wsm_edge_sync
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // pin side
    input wire logic pinIn,
    // synchronous side
    output logic levelOut,
    output logic risePulse
);
    logic meta_q;   // first stage, read only by second stage
    logic sync_q;   // second stage
    logic prev_q;   // delayed copy for edge detection
    logic rise_q;   // registered edge pulse

    // synchroniser chain and edge register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            rise_q <= 1'b0;
        end
        else
        begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
            rise_q <= sync_q & ~prev_q;
        end
    end

    assign levelOut = prev_q;
    assign risePulse = rise_q;
endmodule : wsm_edge_sync

// File: tb/wsm_win_src.sv
// Purpose: far-side source of the window pin
// Assumes: gap of at least 4 cycles
// Notes: one rising edge every gap cycles while go is high
`timescale 1ns/1ps
module wsm_win_src
(
    // clock
    input wire logic clk_sys,
    // control from the bench
    input wire logic go,
    input wire logic [7:0] gap,
    // window pin
    output logic win
);
    logic [7:0] cnt_q; // position inside one window
    // wraps every gap cycles, parked at zero while idle
    always_ff @(posedge clk_sys)
    begin
        cnt_q <= (!go || cnt_q >= gap - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
    // high in the first half of each window
    assign win = go && (cnt_q < (gap >> 1));
endmodule : wsm_win_src

// File: tb/wsm_timer_monitor.sv
// Purpose: port checker for the measure timer
// Assumes: one clock domain
// Notes: attached to every timer instance
`timescale 1ns/1ps
module wsm_timer_monitor
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control and software side
    input wire logic enable,
    input wire logic narrowMode,
    input wire logic swWrite,
    input wire logic swRead,
    input wire logic [1:0] swTarget,
    input wire logic [1:0] swByte,
    input wire logic [wsm_pkg::WSM_BYTE_W-1:0] swRdata,
    input wire logic swRvalid,
    // events
    input wire logic periodMatchIrq,
    input wire logic acqDoneIrq,
    input wire logic running
);
    import wsm_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // every read request is answered in the next cycle
    property p_rvalid; swRead |=> swRvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    // no answer without a request
    property p_quiet; !swRead |=> !swRvalid; endproperty
    a_quiet: assert property (p_quiet) else $error("spurious read answer");
    // read data only move with an answer
    property p_hold; !swRvalid |-> $stable(swRdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // a narrow count cycle leaves the counter upper byte at zero
    property p_narrow;
        swRvalid && $past(narrowMode, 2) && $past(enable, 2) && $past(running, 2)
            && !$past(swWrite, 2) && $past(swTarget) == WSM_TGT_COUNT
            && $past(swByte) == WSM_SEL_UPPER |-> swRdata == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper byte set in narrow");
    // match flag only from a running counter
    property p_match; periodMatchIrq |-> $past(running); endproperty
    a_match: assert property (p_match) else $error("match while idle");
    // completion only from a running measurement
    property p_done; acqDoneIrq |-> $past(running); endproperty
    a_done: assert property (p_done) else $error("done while idle");
    // completion is a single-cycle pulse
    property p_pulse; acqDoneIrq |=> !acqDoneIrq; endproperty
    a_pulse: assert property (p_pulse) else $error("done not a pulse");
    // a start needs enable
    property p_start; $rose(running) |-> $past(enable); endproperty
    a_start: assert property (p_start) else $error("start while disabled");
    // dropping enable stops the measurement
    property p_stop; !enable |=> !running; endproperty
    a_stop: assert property (p_stop) else $error("run after disable");
    // main scenarios reached
    c_done: cover property (acqDoneIrq);
    c_match: cover property (periodMatchIrq);
    c_start: cover property ($rose(running));
    c_narrow: cover property (swRvalid && narrowMode);
endmodule : wsm_timer_monitor
bind wsm_timer wsm_timer_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .enable(enable),
    .narrowMode(narrowMode), .swWrite(swWrite), .swRead(swRead), .swTarget(swTarget),
    .swByte(swByte), .swRdata(swRdata), .swRvalid(swRvalid),
    .periodMatchIrq(periodMatchIrq), .acqDoneIrq(acqDoneIrq), .running(running));

// File: tb/windowed_signal_measure_timer_test.sv
// Purpose: self-checking bench for the measure timer
// Assumes: 250 MHz clock, window from the source model
// Notes: each scenario is its own task
`timescale 1ns/1ps
module windowed_signal_measure_timer_test;
    import wsm_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, enable = 1'b0, narrowMode = 1'b0, win, go = 1'b0;
    logic swWrite = 1'b0, swRead = 1'b0, swRvalid, periodMatchIrq, acqDoneIrq, running;
    logic windowLevel; // synchronised pin level seen by the timer
    logic [1:0] swTarget = 2'h0, swByte = 2'h0;
    logic [7:0] swWdata = 8'h00, swRdata, gap = 8'h14;
    int fail_count = 0, n_tests = 0;
    always #2 clk_sys = ~clk_sys; // 4 ns period
    wsm_win_src src (.clk_sys(clk_sys), .go(go), .gap(gap), .win(win));
    wsm_timer uut (.clk_sys(clk_sys), .rstn(rstn), .enable(enable), .narrowMode(narrowMode),
        .window_gate_input(win), .swWrite(swWrite), .swRead(swRead), .swTarget(swTarget),
        .swByte(swByte), .swWdata(swWdata), .swRdata(swRdata), .swRvalid(swRvalid),
        .periodMatchIrq(periodMatchIrq), .acqDoneIrq(acqDoneIrq), .windowLevel(windowLevel),
        .running(running));
    // verdict and end of run
    task wrap_up;
        if (fail_count == 0 && n_tests > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // one byte access; a read is judged just after the clock edge that takes it
    task sw(input logic w, input logic [1:0] t, input logic [1:0] b, input logic [7:0] d);
        @(posedge clk_sys);
        swWrite <= w;
        swRead <= !w;
        swTarget <= t;
        swByte <= b;
        swWdata <= d;
        @(posedge clk_sys);
        swWrite <= 1'b0;
        swRead <= 1'b0;
        #1;
        // answer stands for this one cycle only
        if (!w)
        begin
            chk({7'h00, swRvalid}, 8'h01);
            chk(swRdata, d);
        end
    endtask : sw
    // bounded wait on one event output
    task wt(input logic m);
        for (int i = 0; i < 200; i++)
        begin
            @(posedge clk_sys);
            #1;
            if (m ? periodMatchIrq : acqDoneIrq)
                return;
        end
        // no event in time counts as a mismatch
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        fail_count++;
        wrap_up();
    endtask : wt
    // reset values and byte access while idle
    task t_regs;
        sw(1'b0, WSM_TGT_MATCH, WSM_SEL_UPPER, 8'hFF);
        sw(1'b0, WSM_TGT_CAPA, WSM_SEL_LOW, 8'h00);
        sw(1'b1, WSM_TGT_CAPA, WSM_SEL_UPPER, 8'h3C);
        sw(1'b0, WSM_TGT_CAPA, WSM_SEL_UPPER, 8'h3C);
        sw(1'b1, WSM_TGT_CAPB, WSM_SEL_HIGH, 8'hA5);
        sw(1'b0, WSM_TGT_CAPB, WSM_SEL_HIGH, 8'hA5);
        for (int b = 0; b < 3; b++)
        begin
            sw(1'b1, WSM_TGT_COUNT, b[1:0], 8'h5A + 8'(b));
            sw(1'b0, WSM_TGT_COUNT, b[1:0], 8'h5A + 8'(b));
        end
        // byte code 3 reads zero and drops writes
        sw(1'b0, WSM_TGT_COUNT, 2'h3, 8'h00);
        sw(1'b1, WSM_TGT_COUNT, 2'h3, 8'hFF);
        sw(1'b0, WSM_TGT_COUNT, WSM_SEL_LOW, 8'h5A);
    endtask : t_regs
    // windowed measurement of a steady window period
    task t_window;
        @(posedge clk_sys);
        enable <= 1'b1;
        go <= 1'b1;
        wt(1'b0);
        chk({7'h00, windowLevel}, 8'h01);
        wt(1'b0);
        sw(1'b0, WSM_TGT_CAPA, WSM_SEL_LOW, gap - 8'h01);
        sw(1'b0, WSM_TGT_CAPA, WSM_SEL_HIGH, 8'h00);
        sw(1'b0, WSM_TGT_CAPA, WSM_SEL_UPPER, 8'h00);
        sw(1'b0, WSM_TGT_CAPB, WSM_SEL_LOW, gap - 8'h01);
    endtask : t_window
    // match flag once per window, counter keeps going
    task t_match;
        for (int b = 0; b < 3; b++)
        begin
            sw(1'b1, WSM_TGT_MATCH, b[1:0], b == 0 ? 8'h05 : 8'h00);
        end
        wt(1'b1);
        // flag one cycle after the hit, read taken two cycles later
        sw(1'b0, WSM_TGT_COUNT, WSM_SEL_LOW, 8'h07);
        wt(1'b1);
    endtask : t_match
    // narrow width, then disable
    task t_narrow;
        @(posedge clk_sys);
        narrowMode <= 1'b1;
        sw(1'b1, WSM_TGT_COUNT, WSM_SEL_UPPER, 8'h12);
        sw(1'b0, WSM_TGT_COUNT, WSM_SEL_UPPER, 8'h00);
        @(posedge clk_sys);
        enable <= 1'b0;
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({7'h00, running}, 8'h00);
    endtask : t_narrow
    // idle pin level, then a reset while the timer is stopped
    task t_reset;
        repeat (6) @(posedge clk_sys);
        #1;
        chk({7'h00, windowLevel}, 8'h00);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        sw(1'b0, WSM_TGT_MATCH, WSM_SEL_LOW, 8'hFF);
        sw(1'b0, WSM_TGT_CAPA, WSM_SEL_LOW, 8'h00);
        sw(1'b0, WSM_TGT_COUNT, WSM_SEL_HIGH, 8'h00);
    endtask : t_reset
    // scenario order
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs();
        t_window();
        t_match();
        t_narrow();
        t_reset();
        wrap_up();
    end
endmodule : windowed_signal_measure_timer_test
